/* common/tdc_seq_pkg.sv */
/*
  constants shared by the sequencer ends: link register map, control
  bit positions, reset values, word formats and timing counts.
  assumes one 20 MHz system clock shared by both ends.
*/
package tdc_seq_pkg;
  // link widths
  localparam int ADDR_W = 16;  // register offset width
  localparam int DATA_W = 32;  // link data width
  localparam int BUF_AW = 11;  // output buffer address width
  localparam int CH_N   = 32;  // channels per event

  // device register offsets on the link
  localparam logic [15:0] OFF_OUT_BUF    = 16'h0000;  // output buffer read
  localparam logic [15:0] OFF_BCAST_BASE = 16'h1004;  // broadcast/chain base
  localparam logic [15:0] OFF_INT_LEVEL  = 16'h100a;  // interrupt level
  localparam logic [15:0] OFF_INT_VECTOR = 16'h100c;  // interrupt vector
  localparam logic [15:0] OFF_EVCNT      = 16'h1024;  // event counter read
  localparam logic [15:0] OFF_CTRL_SET   = 16'h1032;  // second control set port
  localparam logic [15:0] OFF_CTRL_CLR   = 16'h1034;  // second control clear port
  localparam logic [15:0] OFF_W_TEST_AD  = 16'h1036;  // test write address
  localparam logic [15:0] OFF_TWORD_HI   = 16'h1038;  // test word upper half
  localparam logic [15:0] OFF_TWORD_LO   = 16'h103a;  // test word lower half
  localparam logic [15:0] OFF_TEST_EVENT = 16'h103e;  // test event fifo write
  localparam logic [15:0] OFF_EVCNT_RST  = 16'h1040;  // event counter clear
  localparam logic [15:0] OFF_R_TEST_AD  = 16'h1064;  // test read address
  localparam logic [15:0] OFF_THR_BASE   = 16'h1080;  // first threshold word
  localparam logic [15:0] OFF_THR_LAST   = 16'h10be;  // last threshold word

  // second control register bit positions
  localparam int B_MEM_TEST  = 0;   // random memory access test
  localparam int B_OVF_OFF   = 3;   // overflow suppression disabled
  localparam int B_ZERO_OFF  = 4;   // zero suppression disabled
  localparam int B_VALID_CTL = 5;   // validity control
  localparam int B_ACQ_TEST  = 6;   // acquisition_test_select
  localparam int B_EMPTY_EN  = 12;  // empty_event_write_enable
  localparam int B_CNT_ALL   = 14;  // count every trigger, not only accepted
  localparam int THR_KILL    = 8;   // kill bit in a threshold word

  // reset values
  localparam logic [7:0]  BCAST_RESET = 8'haa;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  // output word type codes, bits 26:24
  localparam logic [2:0] T_DATA   = 3'h0;
  localparam logic [2:0] T_HEADER = 3'h2;
  localparam logic [2:0] T_EOB    = 3'h4;
  localparam logic [2:0] T_NVALID = 3'h6;

  // timing
  localparam int CLK_NS       = 50;    // sys_clk period
  localparam int TAC_NS       = 1200;  // time-to-amplitude window, least
  localparam int TAC_CYCLES   = (TAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_WORDS  = CH_N + 2;  // largest event in words

  // host command register offsets (apb)
  localparam logic [7:0] H_LINK_ADDR  = 8'h00;
  localparam logic [7:0] H_LINK_WDATA = 8'h04;
  localparam logic [7:0] H_CMD        = 8'h08;
  localparam logic [7:0] H_STATUS     = 8'h0c;
  localparam logic [7:0] H_LINK_RDATA = 8'h10;
  localparam int HC_GO   = 0;  // start one link access
  localparam int HC_WR   = 1;  // access is a write
  localparam int HC_TRIG = 2;  // fire one conversion_trigger
endpackage

/* common/tdc_link_if.sv */
/*
  link between the sequencer controller and the converter sequencer:
  a request/acknowledge register port plus trigger and busy.
  assumes both ends run on the same sys_clk.
*/
`timescale 1ns/1ps
interface tdc_link_if;
  logic        req;                 // access request, held until ack
  logic        we;                  // 1 write, 0 read
  logic [15:0] addr;                // register offset
  logic [31:0] wdata;               // write data
  logic        ack;                 // one-cycle answer
  logic [31:0] rdata;               // read data, valid with ack
  logic        conversion_trigger;  // start of an event
  logic        busy;                // device refuses triggers

  modport device (input req, we, addr, wdata, conversion_trigger,
                  output ack, rdata, busy);
  modport host   (output req, we, addr, wdata, conversion_trigger,
                  input ack, rdata, busy);
endinterface

/* src/tdc_sequencer.sv */
/*
  converter acquisition sequencer: register port, conversion sequence,
  event framing into the output buffer, memory and acquisition test modes.
  assumes the front end returns the sample of chan_sel in the same cycle.
*/
// Register access over APB was left to the implementer.
// Operation
// - reset zeroes counter and pointers, leaving buffer empty
// - reset loads interrupt level and vector zero
// - reset sets broadcast chain base to aa
// - master writes thresholds, reinitialises after reset
// - idle trigger starts sections; busy triggers ignored
// - accepted trigger bumps event counter per setting
// - busy high until done, held while full
// - abort during section phase cancels conversion
// - suppress, then frame accepted values header/end
// - empty event, enable low: nothing written
// - empty event, enable high: header and end
// - end clears sections and drops busy
// - control bit 0 enables memory test writes
// - control bit 6 selects acquisition test
// - lower half write commits 32-bit word
// - master keeps read and write addresses apart
// - setting test select resets fifo write pointer
// - clearing resets read pointer, frees writes
// - setting again resets write, frees reads
// - 32-entry circular fifo, channel order interleaved
// - master writes value and overflow words
// - test event delivered in written order
`timescale 1ns/1ps
module tdc_sequencer
  import tdc_seq_pkg::*;
#(
  parameter int TAC_LEN = TAC_CYCLES  // section window in cycles
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // link to the controller
  tdc_link_if.device       lk,
  // front end
  input  wire logic [13:0] chan_sample,  // value 11:0, overflow 12
  input  wire logic        abort_req,    // reset or quick-abort
  output logic      [4:0]  chan_sel,
  output logic             tac_run,
  output logic             tac_clear
);
  import tdc_seq_pkg::*;

  typedef enum {S_IDLE, S_TAC, S_SAMPLE, S_HEADER, S_EOB, S_CLEAR} state_t;

  state_t              state;          // sequence state
  logic [31:0]         obuf [0:2047];  // output buffer
  logic [15:0]         tfifo [0:31];   // acquisition test fifo
  logic [8:0]          thr [0:31];     // kill bit and threshold
  logic [15:0]         ctrl;           // second control register
  logic [7:0]          bcast_base;     // broadcast/chain base
  logic [2:0]          int_level;      // kept, no interrupt logic here
  logic [7:0]          int_vector;
  logic [23:0]         ev_cnt;         // event counter
  logic [BUF_AW-1:0]   wr_ptr;         // next event start
  logic [BUF_AW-1:0]   rd_ptr;         // next word to read
  logic [BUF_AW-1:0]   w_test_ad;      // memory test write address
  logic [BUF_AW-1:0]   r_test_ad;      // memory test read address
  logic [15:0]         tword_hi;       // held upper half
  logic [4:0]          tf_wptr;        // test fifo pointers
  logic [4:0]          tf_rptr;
  logic                tf_wrun;        // writes advance tf_wptr
  logic                tf_rrun;        // events advance tf_rptr
  logic [15:0]         tac_cnt;
  logic [5:0]          idx;            // readout slot 0..31
  logic [5:0]          n_acc;          // accepted words so far

  // decode of one link access, taken while ack is low
  wire                 take    = lk.req & ~lk.ack;
  wire                 wr      = take & lk.we;
  wire                 rd      = take & ~lk.we;
  wire                 w_set   = wr & (lk.addr == OFF_CTRL_SET);
  wire                 w_clr   = wr & (lk.addr == OFF_CTRL_CLR);
  wire                 w_thr   = wr & (lk.addr >= OFF_THR_BASE) & (lk.addr <= OFF_THR_LAST);
  wire [4:0]           thr_ch  = 5'((lk.addr - OFF_THR_BASE) >> 1);
  wire                 acq_set = w_set & lk.wdata[B_ACQ_TEST];
  wire                 acq_clr = w_clr & lk.wdata[B_ACQ_TEST];
  wire                 w_tlo   = wr & (lk.addr == OFF_TWORD_LO) & ctrl[B_MEM_TEST];
  wire                 w_tev   = wr & (lk.addr == OFF_TEST_EVENT);
  wire                 r_buf   = rd & (lk.addr == OFF_OUT_BUF);

  // buffer occupancy; full once a largest event no longer fits
  wire [BUF_AW-1:0]    used    = wr_ptr - rd_ptr;
  wire                 full    = used > BUF_AW'(2047 - FRAME_WORDS);
  // busy lags the state by a cycle; a trigger is refused while busy still shows
  wire                 idle_ok = (state == S_IDLE) & ~full & ~lk.busy;
  wire                 trig_ok = lk.conversion_trigger & idle_ok;

  // channel of the next slot: order 0,16,1,17 .. 15,31
  wire [5:0]           idx_inc = idx + 6'h01;
  wire [4:0]           slot_ch = {idx_inc[0], idx_inc[4:1]};
  wire                 acq_on  = ctrl[B_ACQ_TEST] & tf_rrun;
  wire [13:0]          sample  = acq_on ? tfifo[tf_rptr][13:0] : chan_sample;
  wire                 zero_ok = ctrl[B_ZERO_OFF] | (sample[11:4] >= thr[chan_sel][7:0]);
  wire                 ovf_ok  = ctrl[B_OVF_OFF] | ~sample[12];
  wire                 accept  = zero_ok & ovf_ok & ~thr[chan_sel][THR_KILL];
  wire                 no_data = (n_acc == 6'h00);

  // word formats
  wire [31:0]          w_data  = {5'h00, T_DATA, 3'h0, chan_sel, 2'h0, sample};
  wire [31:0]          w_head  = {5'h00, T_HEADER, 10'h000, n_acc, 8'h00};
  wire [31:0]          w_eob   = {5'h00, T_EOB, ev_cnt};

  // one buffer write port, sequence first, memory test second
  logic                mem_we;
  logic [BUF_AW-1:0]   mem_ad;
  logic [31:0]         mem_d;
  always_comb
  begin
    mem_we = 1'b0;
    mem_ad = w_test_ad;
    mem_d  = {tword_hi, lk.wdata[15:0]};
    case (state)
      S_SAMPLE:
      begin
        mem_we = accept;
        mem_ad = wr_ptr + BUF_AW'(n_acc) + BUF_AW'(1);
        mem_d  = w_data;
      end
      S_HEADER:
      begin
        mem_we = 1'b1;
        mem_ad = wr_ptr;
        mem_d  = w_head;
      end
      S_EOB:
      begin
        mem_we = 1'b1;
        mem_ad = wr_ptr + BUF_AW'(n_acc) + BUF_AW'(1);
        mem_d  = w_eob;
      end
      default:
        mem_we = w_tlo;
    endcase
  end

  // memories without reset: their contents are meaningless until written
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      obuf[mem_ad] <= mem_d;
    if (w_tev)
      tfifo[tf_wptr] <= lk.wdata[15:0];
    if (w_thr)
      thr[thr_ch] <= lk.wdata[8:0];
  end

  // register port: answer and read data one cycle after the take
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lk.ack   <= 1'b0;
      lk.rdata <= 32'h0000_0000;
    end
    else
    begin
      lk.ack <= take;
      if (r_buf && ctrl[B_MEM_TEST])
        lk.rdata <= obuf[r_test_ad];
      else if (r_buf)
        lk.rdata <= (used != '0) ? obuf[rd_ptr] : {5'h00, T_NVALID, 24'h000000};
      else if (rd && lk.addr == OFF_EVCNT)
        lk.rdata <= {8'h00, ev_cnt};
      else if (rd && lk.addr == OFF_CTRL_SET)
        lk.rdata <= {16'h0000, ctrl};
      else if (rd && lk.addr == OFF_BCAST_BASE)
        lk.rdata <= {24'h000000, bcast_base};
      else if (rd && lk.addr == OFF_INT_LEVEL)
        lk.rdata <= {29'h0, int_level};
      else if (rd && lk.addr == OFF_INT_VECTOR)
        lk.rdata <= {24'h000000, int_vector};
      else if (rd)
        lk.rdata <= 32'h0000_0000;  // unmapped or write-only
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ctrl       <= CTRL_RESET;
      bcast_base <= BCAST_RESET;
      int_level  <= 3'h0;
      int_vector <= 8'h00;
      w_test_ad  <= '0;
      r_test_ad  <= '0;
      tword_hi   <= 16'h0000;
    end
    else
    begin
      if (w_set)
        ctrl <= ctrl | lk.wdata[15:0];
      else if (w_clr)
        ctrl <= ctrl & ~lk.wdata[15:0];
      if (wr && lk.addr == OFF_BCAST_BASE)
        bcast_base <= lk.wdata[7:0];
      if (wr && lk.addr == OFF_INT_LEVEL)
        int_level <= lk.wdata[2:0];
      if (wr && lk.addr == OFF_INT_VECTOR)
        int_vector <= lk.wdata[7:0];
      if (wr && lk.addr == OFF_W_TEST_AD)
        w_test_ad <= lk.wdata[BUF_AW-1:0];
      if (wr && lk.addr == OFF_R_TEST_AD)
        r_test_ad <= lk.wdata[BUF_AW-1:0];
      if (wr && lk.addr == OFF_TWORD_HI)
        tword_hi <= lk.wdata[15:0];
    end
  end

  // test fifo pointers; select and release follow the set/clear sequence
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tf_wptr <= 5'h00;
      tf_rptr <= 5'h00;
      tf_wrun <= 1'b0;
      tf_rrun <= 1'b0;
    end
    else
    begin
      if (acq_set)
      begin
        tf_wptr <= 5'h00;
        tf_wrun <= 1'b0;
        tf_rrun <= 1'b1;
      end
      else if (acq_clr)
      begin
        tf_rptr <= 5'h00;
        tf_wrun <= 1'b1;
        tf_rrun <= 1'b0;
      end
      else
      begin
        if (w_tev && tf_wrun)
          tf_wptr <= tf_wptr + 5'h01;  // wraps at 32
        if (state == S_SAMPLE && acq_on)
          tf_rptr <= tf_rptr + 5'h01;
      end
    end
  end

  // conversion sequence, pointers and event counter
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state     <= S_IDLE;
      ev_cnt    <= 24'h000000;
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      tac_cnt   <= 16'h0000;
      idx       <= 6'h00;
      n_acc     <= 6'h00;
      chan_sel  <= 5'h00;
      tac_run   <= 1'b0;
      tac_clear <= 1'b0;
      lk.busy   <= 1'b0;
    end
    else
    begin
      tac_clear <= 1'b0;
      lk.busy   <= (state != S_IDLE) | trig_ok | full;
      if (r_buf && !ctrl[B_MEM_TEST] && used != '0)
        rd_ptr <= rd_ptr + BUF_AW'(1);
      // counter clear loses to a counted trigger in the same cycle
      if (lk.conversion_trigger && (trig_ok || ctrl[B_CNT_ALL]))
        ev_cnt <= ev_cnt + 24'h000001;
      else if (wr && lk.addr == OFF_EVCNT_RST)
        ev_cnt <= 24'h000000;
      case (state)
        S_IDLE:
          if (trig_ok)
          begin
            state   <= S_TAC;
            tac_run <= 1'b1;
            tac_cnt <= 16'h0000;
          end
        S_TAC:
          if (abort_req)
          begin
            state <= S_CLEAR;
          end
          else if (tac_cnt == 16'(TAC_LEN - 1))
          begin
            state    <= S_SAMPLE;
            tac_run  <= 1'b0;
            idx      <= 6'h00;
            n_acc    <= 6'h00;
            chan_sel <= 5'h00;
          end
          else
            tac_cnt <= tac_cnt + 16'h0001;
        S_SAMPLE:
        begin
          if (accept)
            n_acc <= n_acc + 6'h01;
          if (idx == 6'(CH_N - 1))
            state <= (no_data && !accept && !ctrl[B_EMPTY_EN]) ? S_CLEAR : S_HEADER;
          idx      <= idx + 6'h01;
          chan_sel <= slot_ch;
        end
        S_HEADER:
          state <= S_EOB;
        S_EOB:
        begin
          wr_ptr <= wr_ptr + BUF_AW'(n_acc) + BUF_AW'(2);
          state  <= S_CLEAR;
        end
        S_CLEAR:
        begin
          tac_run   <= 1'b0;
          tac_clear <= 1'b1;
          state     <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

/* src/tdc_seq_controller.sv */
/*
  controller end: an apb slave whose registers order single link
  accesses and conversion triggers, and report link and busy status.
  assumes the sequencer on the link shares sys_clk.
*/
`timescale 1ns/1ps
module tdc_seq_controller
  import tdc_seq_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link to the sequencer
  tdc_link_if.host         lk
);
  import tdc_seq_pkg::*;

  logic [15:0] link_addr;   // offset for the next access
  logic [31:0] link_wdata;  // data for the next write
  logic [31:0] link_rdata;  // data of the last read

  // access taken on the second access cycle, answered with pready
  wire         acc     = psel & penable & ~pready;
  wire         wr      = acc & pwrite;
  wire         mapped  = (paddr == H_LINK_ADDR) | (paddr == H_LINK_WDATA) |
                         (paddr == H_CMD) | (paddr == H_STATUS) |
                         (paddr == H_LINK_RDATA);
  wire         w_cmd   = wr & (paddr == H_CMD);
  // a new access is refused while one is still waiting for ack
  wire         go      = w_cmd & pwdata[HC_GO] & ~lk.req;
  wire [31:0]  rd_val  = (paddr == H_LINK_ADDR)  ? {16'h0000, link_addr} :
                         (paddr == H_LINK_WDATA) ? link_wdata :
                         (paddr == H_STATUS)     ? {30'h0, lk.busy, lk.req} :
                         (paddr == H_LINK_RDATA) ? link_rdata : 32'h0000_0000;

  // apb answer and host registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      link_addr  <= 16'h0000;
      link_wdata <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc)
        prdata <= rd_val;
      if (wr && paddr == H_LINK_ADDR)
        link_addr <= pwdata[15:0];
      if (wr && paddr == H_LINK_WDATA)
        link_wdata <= pwdata;
    end
  end

  // link request held until the one-cycle ack; trigger is one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lk.req                <= 1'b0;
      lk.we                 <= 1'b0;
      lk.addr               <= 16'h0000;
      lk.wdata              <= 32'h0000_0000;
      lk.conversion_trigger <= 1'b0;
      link_rdata            <= 32'h0000_0000;
    end
    else
    begin
      // a trigger during busy is dropped by the sequencer
      lk.conversion_trigger <= w_cmd & pwdata[HC_TRIG];
      if (go)
      begin
        lk.req   <= 1'b1;
        lk.we    <= pwdata[HC_WR];
        lk.addr  <= link_addr;   // software keeps addresses apart
        lk.wdata <= link_wdata;  // sequence is software's
      end
      else if (lk.ack)
        lk.req <= 1'b0;
      if (lk.ack && !lk.we)
        link_rdata <= lk.rdata;
    end
  end
endmodule

/* tb/tdc_link_assertions.sv */
/*
  checker for the link between controller and sequencer: request and
  answer timing, trigger pulses and busy behaviour.
  assumes it is instantiated beside the link interface on sys_clk.
*/
`timescale 1ns/1ps
module tdc_link_assertions (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        conversion_trigger,
  input wire logic        busy
);
  // one domain, so clock and disable are declared once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_ack_follows_req: assert property (req && !ack |=> ack)
    else $error("link ack missing one cycle after request");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  a_req_held_stable: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata)
    && $stable(we))
    else $error("link request changed before ack");
  a_req_drops_after: assert property (ack |=> !req)
    else $error("link request not dropped after ack");
  a_trig_is_pulse: assert property (conversion_trigger |=> !conversion_trigger)
    else $error("trigger longer than one cycle");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(conversion_trigger))
    else $error("busy rose without a trigger");
  a_busy_holds_run: assert property (conversion_trigger && !busy |=> busy [*8])
    else $error("busy not held through conversion");
  a_rdata_only_ack: assert property ($changed(rdata) |-> ack)
    else $error("read data changed without ack");

  // main traffic seen
  c_read: cover property (req && !we ##1 ack);
  c_write: cover property (req && we ##1 ack);
  c_event: cover property (conversion_trigger && !busy ##1 busy);
  c_busy_end: cover property ($fell(busy));
endmodule

/* tb/tdc_acquisition_sequencer_test_modes_test.sv */
/*
  testbench: apb drives the controller, which orders the sequencer over
  the link; covers reset values, events, empty events and both test modes.
  assumes a short section window (TAC_LEN 2) to keep the run brief.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tdc_acquisition_sequencer_test_modes_test;
  import tdc_seq_pkg::*;
  logic        sys_clk = 0;      // 20 MHz
  logic        reset_n = 0;      // sync, active low
  logic [7:0]  paddr = 0;        // apb address
  logic        psel = 0;         // apb select
  logic        penable = 0;      // apb access phase
  logic        pwrite = 0;       // apb direction
  logic [31:0] pwdata = 0;       // apb write data
  logic [31:0] prdata;           // apb read data
  logic        pready;           // apb answer
  logic        pslverr;          // apb error
  logic [4:0]  chan_sel;         // channel being sampled
  logic [13:0] chan_sample;      // front-end sample
  logic        tac_run;          // sections running
  logic        tac_clear;        // end-of-sequence pulse
  logic        abort_req = 0;    // reset or quick-abort request
  int          bad_count = 0;    // mismatches
  int          check_count = 0;  // comparisons
  // each channel answers with its own number in the value field
  assign chan_sample = {5'h00, chan_sel, 4'h5};
  tdc_link_if lk_bus();
  tdc_sequencer #(.TAC_LEN(2)) i_tdc_sequencer (.sys_clk(sys_clk), .reset_n(reset_n),
    .lk(lk_bus), .chan_sample(chan_sample), .abort_req(abort_req), .chan_sel(chan_sel),
    .tac_run(tac_run), .tac_clear(tac_clear));
  tdc_seq_controller i_tdc_seq_controller (.sys_clk(sys_clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(lk_bus));
  tdc_link_assertions i_tdc_link_assertions (.sys_clk(sys_clk), .reset_n(reset_n),
    .req(lk_bus.req), .we(lk_bus.we), .addr(lk_bus.addr), .wdata(lk_bus.wdata),
    .ack(lk_bus.ack), .rdata(lk_bus.rdata), .conversion_trigger(lk_bus.conversion_trigger),
    .busy(lk_bus.busy));

  // clock generator
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task automatic close_out;
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll a status bit until it clears, bounded
  task automatic wait_clear(input int b);
    logic [31:0] s;
    logic        e;
    int          n;
    s = 32'h3;
    n = 0;
    while (s[b] !== 1'b0 && n < 200)
    begin
      apb(1'b0, H_STATUS, 32'h0, s, e);
      n++;
    end
    if (n == 200)
      bad_count++;  // poll limit ran out
  endtask

  // one register access on the device through the controller
  task automatic lk_io(input logic [15:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] r);
    logic e;
    apb(1'b1, H_LINK_ADDR, {16'h0000, a}, r, e);
    apb(1'b1, H_LINK_WDATA, d, r, e);
    apb(1'b1, H_CMD, {30'h0, w, 1'b1}, r, e);
    wait_clear(0);
    apb(1'b0, H_LINK_RDATA, 32'h0, r, e);
  endtask

  task automatic lw(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    lk_io(a, d, 1'b1, r);
  endtask

  // fire one trigger and wait for busy to fall
  task automatic trig;
    logic [31:0] r;
    logic        e;
    apb(1'b1, H_CMD, 32'h4, r, e);
    repeat (3) @(posedge sys_clk);
    wait_clear(1);
  endtask

  // all thresholds with one value; the master must set them first
  task automatic thr_all(input logic [31:0] v);
    for (int c = 0; c < CH_N; c++) lw(OFF_THR_BASE + 16'(2 * c), v);
  endtask

  // read one full event and judge header, data order and end word
  task automatic read_event(input logic acq, input logic [23:0] cnt);
    logic [31:0] w;
    logic [4:0]  ch;
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, w);
    `CHK(w[26:24], T_HEADER)
    `CHK(w[13:8], 6'd32)
    for (int i = 0; i < CH_N; i++)
    begin
      ch = 5'(i / 2 + (i % 2) * 16);
      lk_io(OFF_OUT_BUF, 32'h0, 1'b0, w);
      `CHK(w[20:16], ch)
      `CHK(w[13:0], acq ? 14'(12'h200 + i) : {5'h00, ch, 4'h5})
    end
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, w);
    `CHK(w[26:24], T_EOB)
    `CHK(w[23:0], cnt)
  endtask

  // reset values of the device and refusals of both ports
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    lk_io(OFF_BCAST_BASE, 32'h0, 1'b0, r);
    `CHK(r[7:0], BCAST_RESET)
    lk_io(OFF_INT_LEVEL, 32'h0, 1'b0, r);
    `CHK(r[2:0], 3'h0)
    lk_io(OFF_INT_VECTOR, 32'h0, 1'b0, r);
    `CHK(r[7:0], 8'h00)
    lk_io(OFF_EVCNT, 32'h0, 1'b0, r);
    `CHK(r[23:0], 24'h000000)
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK(r, 32'h06000000)
    lk_io(16'h2000, 32'h0, 1'b0, r);
    `CHK(r, 32'h00000000)
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK(e, 1'b1)
  endtask

  // a trigger during busy is ignored; the counter moves once
  task automatic t_busy;
    logic [31:0] r;
    logic        e;
    apb(1'b1, H_CMD, 32'h4, r, e);
    apb(1'b1, H_CMD, 32'h4, r, e);
    wait_clear(1);
    lk_io(OFF_EVCNT, 32'h0, 1'b0, r);
    `CHK(r[23:0], 24'd2)
    read_event(1'b0, 24'd2);
  endtask

  // events with no accepted channel, without and with the enable
  task automatic t_empty;
    logic [31:0] r;
    thr_all(32'h100);
    trig();
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK(r, 32'h06000000)
    lw(OFF_CTRL_SET, 32'h1 << B_EMPTY_EN);
    trig();
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK({r[26:24], r[13:8]}, {T_HEADER, 6'd0})
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK({r[26:24], r[23:0]}, {T_EOB, 24'd4})
    lw(OFF_CTRL_CLR, 32'h1 << B_EMPTY_EN);
    thr_all(32'h0);
  endtask

  // direct buffer write; read and write addresses kept apart
  task automatic t_memtest;
    logic [31:0] r;
    lw(OFF_CTRL_SET, 32'h1 << B_MEM_TEST);
    lw(OFF_R_TEST_AD, 32'h6);
    lw(OFF_W_TEST_AD, 32'h5);
    lw(OFF_TWORD_HI, 32'h1234);
    lw(OFF_TWORD_LO, 32'h5678);
    lw(OFF_W_TEST_AD, 32'h7);
    lw(OFF_R_TEST_AD, 32'h5);
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK(r, 32'h12345678)
    lw(OFF_CTRL_CLR, 32'h1 << B_MEM_TEST);
  endtask

  // fifo loaded with 32 words comes back as an event, in order
  task automatic t_acq;
    lw(OFF_CTRL_SET, 32'h1 << B_VALID_CTL);
    lw(OFF_CTRL_SET, 32'h1 << B_ACQ_TEST);
    lw(OFF_CTRL_CLR, 32'h1 << B_ACQ_TEST);
    for (int i = 0; i < 32; i++) lw(OFF_TEST_EVENT, 32'(12'h200 + i));
    lw(OFF_CTRL_SET, 32'h1 << B_ACQ_TEST);
    trig();
    read_event(1'b1, 24'd5);
    lw(OFF_CTRL_CLR, 32'h1 << B_ACQ_TEST);
  endtask

  // abort in the section phase: nothing stored, sections cleared
  task automatic t_abort;
    logic [31:0] r;
    logic        e;
    apb(1'b1, H_CMD, 32'h4, r, e);
    abort_req <= 1'b1;
    @(negedge sys_clk);
    `CHK(tac_run, 1'b1)
    repeat (2) @(posedge sys_clk);
    abort_req <= 1'b0;
    @(negedge sys_clk);
    `CHK(tac_clear, 1'b1)
    wait_clear(1);
    lk_io(OFF_OUT_BUF, 32'h0, 1'b0, r);
    `CHK(r, 32'h06000000)
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    thr_all(32'h0);
    trig();
    read_event(1'b0, 24'd1);
    t_busy();
    t_empty();
    t_memtest();
    t_acq();
    t_abort();
    close_out();
  end

  // watchdog against a hang
  initial
  begin
    #(50 * 90000);
    bad_count++;
    close_out();
  end
endmodule
